// ==== design/pnwp_host.sv ====
`timescale 1ns/100ps
`default_nettype none
module pnwp_host (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // user request
    input wire logic reqValid,
    output logic reqReady,
    input wire pnwp_pkg::pnwp_req_t req,
    output logic rspValid,
    output logic [15:0] rspData,
    // memory pins
    output logic [16:0] memAddr,
    output pnwp_pkg::pnwp_ctl_t memCtl,
    input wire logic [15:0] memDqIn,
    output logic [15:0] memDqOut,
    output logic [15:0] memDqOe
);
    pnwp_pkg::pnwp_state_t stateFf, nxtState;
    logic [pnwp_pkg::CNT_W-1:0] cntFf;
    logic [3:0] stepFf;
    logic [3:0] lastStep;
    logic writeFf, protFf, hiFf, loFf, rspValidFf;
    logic [16:0] addrFf;
    logic [15:0] wdataFf, rdataFf;
    logic [7:0] protByteFf;
    logic [16:0] stepAddr;
    logic stepWrite;
    logic [15:0] stepData;
    logic accDone, preDone, seqEnd, wrDone;
    logic [16:0] curAddr;
    logic curWrite;
    logic [15:0] curData;
    logic [pnwp_pkg::CNT_W-1:0] csHighCntFf;
    logic csHighSat;

    // ----------------------------------------
    // protect sequence step decode
    // ----------------------------------------
    // step 0 is the leading 00000h access so earlier sequence state in the device never matters
    assign lastStep = 4'hb;
    always_comb begin
        stepWrite = 1'b0;
        stepData = wdataFf;
        case (stepFf)
            4'h0: stepAddr = pnwp_pkg::SEQ_LAST;
            4'h1: stepAddr = pnwp_pkg::SEQ_A0;
            4'h2: stepAddr = pnwp_pkg::SEQ_A1;
            4'h3: stepAddr = pnwp_pkg::SEQ_A2;
            4'h4: stepAddr = pnwp_pkg::SEQ_A3;
            4'h5: stepAddr = pnwp_pkg::SEQ_A4;
            4'h6: stepAddr = pnwp_pkg::SEQ_A5;
            4'h7: begin
                stepAddr = pnwp_pkg::SEQ_A1;
                stepWrite = 1'b1;
                stepData = {8'h00, protByteFf};
            end
            4'h8: begin
                stepAddr = pnwp_pkg::SEQ_A3;
                stepWrite = 1'b1;
                stepData = {8'h00, ~protByteFf};
            end
            4'h9: begin
                stepAddr = pnwp_pkg::SEQ_W2;
                stepWrite = 1'b1;
                stepData = 16'h0000;
            end
            default: stepAddr = pnwp_pkg::SEQ_LAST;
        endcase
    end

    assign accDone = (cntFf == pnwp_pkg::CNT_W'(pnwp_pkg::ACC_CYC - 1));
    assign preDone = (cntFf == pnwp_pkg::CNT_W'(pnwp_pkg::PRE_CYC - 1));
    assign seqEnd = protFf && (stepFf == lastStep - 4'h1);
    // one extra strobe-high cycle inside select keeps data and lanes held as the write closes
    assign wrDone = (cntFf == pnwp_pkg::CNT_W'(pnwp_pkg::WR_CYC));

    // ----------------------------------------
    // access sequencer
    // ----------------------------------------
    // every access is select-framed: select low, access, strobe pulse on writes only, pre-charge
    always_comb begin
        nxtState = stateFf;
        case (stateFf)
            pnwp_pkg::ST_IDLE: if (reqValid) nxtState = pnwp_pkg::ST_NEXT;
            pnwp_pkg::ST_ACC: if (accDone) nxtState = curWrite ? pnwp_pkg::ST_WRP : pnwp_pkg::ST_PRE;
            pnwp_pkg::ST_WRP: if (wrDone) nxtState = pnwp_pkg::ST_PRE;
            pnwp_pkg::ST_PRE: if (preDone) nxtState = (protFf && !seqEnd) ? pnwp_pkg::ST_NEXT : pnwp_pkg::ST_IDLE;
            pnwp_pkg::ST_NEXT: nxtState = pnwp_pkg::ST_ACC;
            default: nxtState = pnwp_pkg::ST_IDLE;
        endcase
    end

    assign reqReady = (stateFf == pnwp_pkg::ST_IDLE);
    assign rspValid = rspValidFf;
    assign rspData = rdataFf;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            stateFf <= pnwp_pkg::ST_IDLE;
            cntFf <= '0;
            stepFf <= 4'h0;
            writeFf <= 1'b0;
            protFf <= 1'b0;
            hiFf <= 1'b0;
            loFf <= 1'b0;
            addrFf <= '0;
            wdataFf <= '0;
            rdataFf <= '0;
            protByteFf <= '0;
            rspValidFf <= 1'b0;
        end else begin
            stateFf <= nxtState;
            cntFf <= (nxtState != stateFf) ? '0 : cntFf + 1'b1;
            rspValidFf <= 1'b0;
            if (stateFf == pnwp_pkg::ST_IDLE && reqValid) begin
                protFf <= req.protect;
                stepFf <= 4'h0;
                protByteFf <= req.protByte;
                writeFf <= req.protect ? 1'b0 : req.write;
                addrFf <= req.protect ? pnwp_pkg::SEQ_LAST : req.addr;
                wdataFf <= req.wdata;
                hiFf <= req.protect ? 1'b1 : req.hiSel;
                loFf <= req.protect ? 1'b1 : req.loSel;
            end
            if (stateFf == pnwp_pkg::ST_ACC && accDone && !curWrite) begin
                rdataFf <= memDqIn;
            end
            if (stateFf == pnwp_pkg::ST_PRE && preDone && protFf && !seqEnd) begin
                stepFf <= stepFf + 4'h1;
            end
            if (stateFf == pnwp_pkg::ST_PRE && preDone && (!protFf || seqEnd)) begin
                rspValidFf <= 1'b1;
            end
        end
    end

    // address settles in ST_NEXT, a cycle before select falls, so the device latches a steady value
    assign curAddr = protFf ? stepAddr : addrFf;
    assign curWrite = protFf ? stepWrite : writeFf;
    assign curData = protFf ? stepData : wdataFf;

    // ----------------------------------------
    // pin drive
    // ----------------------------------------
    logic csLow, weLow, rdPhase, wrPhase;
    assign csLow = (stateFf == pnwp_pkg::ST_ACC) || (stateFf == pnwp_pkg::ST_WRP);
    assign wrPhase = (stateFf == pnwp_pkg::ST_WRP);
    assign weLow = wrPhase && !wrDone;
    assign rdPhase = (stateFf == pnwp_pkg::ST_ACC) && !curWrite;
    assign memAddr = curAddr;
    assign memCtl.csN = !csLow;
    assign memCtl.weN = !weLow;
    assign memCtl.oeN = !rdPhase;
    assign memCtl.hiByteSelN = !(csLow && hiFf);
    assign memCtl.loByteSelN = !(csLow && loFf);
    assign memDqOut = curData;
    assign memDqOe = {{8{wrPhase && hiFf}}, {8{wrPhase && loFf}}};

    // cycles with select high, saturating; reset counts as a finished pre-charge
    assign csHighSat = (csHighCntFf == pnwp_pkg::CNT_W'(pnwp_pkg::PRE_CYC));
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            csHighCntFf <= pnwp_pkg::CNT_W'(pnwp_pkg::PRE_CYC);
        end else if (!memCtl.csN) begin
            csHighCntFf <= '0;
        end else if (!csHighSat) begin
            csHighCntFf <= csHighCntFf + 1'b1;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_strobe_in_select;
        @(posedge clk_sys) disable iff (sys_rst) !memCtl.weN |-> !memCtl.csN;
    endproperty
    a_strobe_in_select: assert property (p_strobe_in_select) else $error("strobe outside select");

    property p_data_held;
        @(posedge clk_sys) disable iff (sys_rst)
            !memCtl.weN ##1 memCtl.weN |-> !memCtl.csN && memDqOe != 16'h0000 &&
                $stable(memDqOut) && $stable(memAddr);
    endproperty
    a_data_held: assert property (p_data_held) else $error("write data not held to end");

    property p_precharge;
        @(posedge clk_sys) disable iff (sys_rst)
            $fell(memCtl.csN) |-> csHighSat;
    endproperty
    a_precharge: assert property (p_precharge) else $error("pre-charge too short");

    property p_addr_stable;
        @(posedge clk_sys) disable iff (sys_rst)
            !memCtl.csN && !$fell(memCtl.csN) |-> $stable(memAddr);
    endproperty
    a_addr_stable: assert property (p_addr_stable) else $error("address moved under select");

    property p_addr_setup;
        @(posedge clk_sys) disable iff (sys_rst) $fell(memCtl.csN) |-> $stable(memAddr);
    endproperty
    a_addr_setup: assert property (p_addr_setup) else $error("address changed with select fall");

    property p_select_bound;
        @(posedge clk_sys) disable iff (sys_rst)
            $fell(memCtl.csN) |-> ##[1:30] memCtl.csN;
    endproperty
    a_select_bound: assert property (p_select_bound) else $error("select held too long");

    sequence s_first_read;
        stateFf == pnwp_pkg::ST_ACC && protFf && stepFf == 4'h1;
    endsequence
    property p_seq_start;
        @(posedge clk_sys) disable iff (sys_rst) s_first_read |-> memAddr == pnwp_pkg::SEQ_A0 && memCtl.weN;
    endproperty
    a_seq_start: assert property (p_seq_start) else $error("bad first protect read");

    property p_complement;
        @(posedge clk_sys) disable iff (sys_rst)
            protFf && stepFf == 4'h8 && !memCtl.weN |-> memDqOut[7:0] == ~protByteFf;
    endproperty
    a_complement: assert property (p_complement) else $error("complement wrong");

    property p_lead_zero;
        @(posedge clk_sys) disable iff (sys_rst)
            protFf && stepFf == 4'h0 && !memCtl.csN |-> memAddr == pnwp_pkg::SEQ_LAST;
    endproperty
    a_lead_zero: assert property (p_lead_zero) else $error("missing leading zero access");

    property p_no_drive_on_read;
        @(posedge clk_sys) disable iff (sys_rst) !memCtl.oeN |-> memDqOe == 16'h0000;
    endproperty
    a_no_drive_on_read: assert property (p_no_drive_on_read) else $error("bus fight on read");
endmodule : pnwp_host
`default_nettype wire

// ==== design/pnwp_pkg.sv ====
package pnwp_pkg;
    // ----------------------------------------
    // bus widths, sequence length and clock period
    // ----------------------------------------
    localparam int ADDR_W = 17;
    localparam int DATA_W = 16;
    localparam int SEQ_LEN = 6;
    localparam int CLK_PERIOD_NS = 5;

    // ----------------------------------------
    // timing in ns and derived cycle counts
    // ----------------------------------------
    localparam int ADDR_ACCESS_TIME_NS = 60;
    localparam int PRECHARGE_MIN_TIME_NS = 60;
    localparam int WRITE_PULSE_NS = 40;
    localparam int CS_LOW_MAX_NS = 10000;
    localparam int ACC_CYC = (ADDR_ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PRE_CYC = (PRECHARGE_MIN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WR_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CS_LOW_MAX_CYC = CS_LOW_MAX_NS / CLK_PERIOD_NS;
    localparam int CNT_W = 12;

    // ----------------------------------------
    // protect sequence addresses
    // ----------------------------------------
    localparam logic [16:0] SEQ_A0 = 17'h12555;
    localparam logic [16:0] SEQ_A1 = 17'h1daaa;
    localparam logic [16:0] SEQ_A2 = 17'h01333;
    localparam logic [16:0] SEQ_A3 = 17'h0eccc;
    localparam logic [16:0] SEQ_A4 = 17'h000ff;
    localparam logic [16:0] SEQ_A5 = 17'h1ff00;
    localparam logic [16:0] SEQ_W2 = 17'h0ff00;
    localparam logic [16:0] SEQ_LAST = 17'h00000;

    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef struct packed {
        logic write;
        logic protect;
        logic [16:0] addr;
        logic [15:0] wdata;
        logic [7:0] protByte;
        logic hiSel;
        logic loSel;
    } pnwp_req_t;

    typedef struct packed {
        logic csN;
        logic weN;
        logic oeN;
        logic hiByteSelN;
        logic loByteSelN;
    } pnwp_ctl_t;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_ACC = 5'h02,
        ST_WRP = 5'h04,
        ST_PRE = 5'h08,
        ST_NEXT = 5'h10
    } pnwp_state_t;
endpackage : pnwp_pkg

// ==== verif/pnwp_mem_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module pnwp_mem_model #(
    parameter int ACC_NS = 55
) (
    // pins from host
    input wire logic [16:0] memAddr,
    input wire pnwp_pkg::pnwp_ctl_t memCtl,
    input wire logic [15:0] bus,
    // device drive
    output logic [15:0] devDq,
    output logic [15:0] devOe,
    output logic [7:0] protBits
);
    logic [15:0] mem [0:131071];
    logic [16:0] seqTab [0:5];
    logic [7:0] pend = 8'h00;
    logic valid = 1'b0;
    logic wrAct = 1'b0;
    logic didWr = 1'b0;
    logic rdEn;
    int step = 0;

    initial begin
        for (int i = 0; i < 131072; i++) mem[i] = 16'h0000;
        seqTab = '{pnwp_pkg::SEQ_A0, pnwp_pkg::SEQ_A1, pnwp_pkg::SEQ_A2, pnwp_pkg::SEQ_A3, pnwp_pkg::SEQ_A4,
                   pnwp_pkg::SEQ_A5};
        protBits = 8'h00;
    end

    // ----------------------------------------
    // access start: select fall or address change
    // ----------------------------------------
    always @(negedge memCtl.csN or memAddr) begin
        valid = 1'b0;
        if (!memCtl.csN) didWr = 1'b0;
        if (!memCtl.csN && memCtl.weN) begin
            valid <= #ACC_NS 1'b1;
        end
        if (!memCtl.csN && !memCtl.weN) wrAct = 1'b1;
    end

    always @(negedge memCtl.weN) if (!memCtl.csN) wrAct = 1'b1;

    // ----------------------------------------
    // write ends at first rising strobe or select
    // ----------------------------------------
    always @(posedge memCtl.weN or posedge memCtl.csN) begin
        if (wrAct) begin
            wrAct = 1'b0;
            didWr = 1'b1;
            if (step == 6) begin
                pend = bus[7:0];
                step = 7;
            end else if (step == 7) begin
                if (bus[7:0] == ~pend) protBits = pend;
                step = (bus[7:0] == ~pend) ? 8 : 0;
            end else if (step == 8) begin
                step = 0;
            end else begin
                step = 0;
                if (!protBits[memAddr[16:14]]) begin
                    if (!memCtl.loByteSelN) mem[memAddr][7:0] = bus[7:0];
                    if (!memCtl.hiByteSelN) mem[memAddr][15:8] = bus[15:8];
                end
            end
        end else if (memCtl.csN && !didWr) begin
            // a strobe-driven write opens as a read, so a read only counts once its access closed unwritten
            step = (step < 6 && memAddr == seqTab[step]) ? step + 1 : (memAddr == seqTab[0]) ? 1 : 0;
        end
    end

    // no drive while the write strobe is low, whatever output drive says
    assign rdEn = valid && !memCtl.csN && memCtl.weN && !memCtl.oeN;
    assign devOe = {{8{rdEn && !memCtl.hiByteSelN}}, {8{rdEn && !memCtl.loByteSelN}}};
    assign devDq = mem[memAddr];
endmodule : pnwp_mem_model
`default_nettype wire

// ==== verif/test_pnwp_host.sv ====
`timescale 1ns/100ps
`default_nettype none
module test_pnwp_host;
    logic clk_sys, sys_rst, reqValid, reqReady, rspValid;
    pnwp_pkg::pnwp_req_t req;
    pnwp_pkg::pnwp_ctl_t memCtl;
    logic [15:0] rspData, memDqIn, memDqOut, memDqOe, devDq, devOe, floatPat, d;
    logic [16:0] memAddr, a, e;
    logic [7:0] protBits, pb;
    logic [15:0] shadow [int];
    logic [16:0] expQ [$];
    logic [16:0] seqA [0:5];
    int n_errors, checked, seed;

    pnwp_host pnwp_host_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .reqValid(reqValid), .reqReady(reqReady),
        .req(req), .rspValid(rspValid), .rspData(rspData), .memAddr(memAddr), .memCtl(memCtl),
        .memDqIn(memDqIn), .memDqOut(memDqOut), .memDqOe(memDqOe));
    pnwp_mem_model pnwp_mem_model_i (.memAddr(memAddr), .memCtl(memCtl), .bus(memDqIn), .devDq(devDq),
        .devOe(devOe), .protBits(protBits));

    // undriven lanes toggle so a stale value never passes
    assign memDqIn = (devOe & devDq) | (~devOe & memDqOe & memDqOut) | (~devOe & ~memDqOe & floatPat);

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) floatPat <= ~floatPat;

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic wrap_up;
        $display("errors=%0d checks=%0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : wrap_up

    task automatic do_req(input logic wr, input logic pr, input logic [16:0] ad, input logic [15:0] wd,
                          input logic [7:0] pbyte, input logic hs, input logic ls, input logic chk,
                          input logic [15:0] exp);
        int n;
        n = 0;
        expQ.push_back({chk, exp});
        reqValid <= 1'b1;
        req <= '{write: wr, protect: pr, addr: ad, wdata: wd, protByte: pbyte, hiSel: hs, loSel: ls};
        do @(negedge clk_sys); while (reqReady !== 1'b1 && ++n < 100);
        if (reqReady !== 1'b1) begin
            n_errors++;
            wrap_up();
        end
        @(posedge clk_sys);
        reqValid <= 1'b0;
        n = 0;
        do @(negedge clk_sys); while (rspValid !== 1'b1 && ++n < 2000);
        if (rspValid !== 1'b1) begin
            n_errors++;
            wrap_up();
        end
        @(posedge clk_sys);
    endtask : do_req

    task automatic wr_word(input logic [16:0] ad, input logic [15:0] wd, input logic hs, input logic ls);
        logic [15:0] old;
        old = shadow.exists(ad) ? shadow[ad] : 16'h0000;
        if (!pb[ad[16:14]]) shadow[ad] = {hs ? wd[15:8] : old[15:8], ls ? wd[7:0] : old[7:0]};
        do_req(1'b1, 1'b0, ad, wd, 8'h00, hs, ls, 1'b0, 16'h0000);
    endtask : wr_word

    task automatic rd_word(input logic [16:0] ad);
        do_req(1'b0, 1'b0, ad, 16'h0000, 8'h00, 1'b1, 1'b1, 1'b1, shadow.exists(ad) ? shadow[ad] : 16'h0000);
    endtask : rd_word

    // results come back in request order
    always @(negedge clk_sys) begin
        if (rspValid === 1'b1) begin
            if (expQ.size() == 0) begin
                check(16'hffff, 16'h0000);
            end else begin
                e = expQ.pop_front();
                if (e[16]) check(rspData, e[15:0]);
            end
        end
    end

    initial begin
        seed = 32'h87005a87;
        seqA = '{pnwp_pkg::SEQ_A0, pnwp_pkg::SEQ_A1, pnwp_pkg::SEQ_A2, pnwp_pkg::SEQ_A3, pnwp_pkg::SEQ_A4,
                 pnwp_pkg::SEQ_A5};
        sys_rst = 1'b1;
        reqValid = 1'b0;
        req = '0;
        floatPat = 16'h5a5a;
        pb = 8'h00;
        n_errors = 0;
        checked = 0;
        repeat (5) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        check({8'h00, protBits}, 16'h0000);
        for (int s = 0; s < 8; s++) begin
            a = {s[2:0], 14'($random(seed))};
            d = 16'($random(seed));
            wr_word(a, d, 1'b1, 1'b1);
            rd_word(a);
            wr_word(a, ~d, 1'b1, 1'b0);
            wr_word(a ^ 17'h00001, d, 1'b0, 1'b1);
            rd_word(a);
            rd_word(a ^ 17'h00001);
        end
        for (int k = 0; k < 2; k++) begin
            pb = k ? 8'h00 : (8'($random(seed)) | 8'h01);
            do_req(1'b0, 1'b1, 17'h00000, 16'h0000, pb, 1'b1, 1'b1, 1'b0, 16'h0000);
            check({8'h00, protBits}, {8'h00, pb});
            for (int s = 0; s < 8; s++) begin
                a = {s[2:0], 14'h0123};
                wr_word(a, 16'($random(seed)), 1'b1, 1'b1);
                rd_word(a);
            end
        end
        // a seventh read must drop the sequence, so the write lands in the array
        for (int i = 0; i < 6; i++) rd_word(seqA[i]);
        rd_word(seqA[0]);
        wr_word(17'h04004, 16'h1234, 1'b1, 1'b1);
        rd_word(17'h04004);
        wrap_up();
    end

    initial begin
        repeat (40000) @(posedge clk_sys);
        n_errors++;
        wrap_up();
    end
endmodule : test_pnwp_host
`default_nettype wire
